// ===== design/pse_cfg.svh
// Purpose: offsets, field positions, reset values of the error interrupt block
// Assumes: byte addresses, one 32-bit word per register
// Notes: bit 12 of the address picks the second controller instance
`ifndef PSE_CFG_SVH
`define PSE_CFG_SVH
`define PSE_AW 13
`define PSE_INST_BIT 12
// register offsets inside one instance
`define PSE_OFF_REV 12'h000
`define PSE_OFF_REEVAL 12'h018
`define PSE_OFF_MPEND 12'h040
`define PSE_OFF_MCLR 12'h050
`define PSE_OFF_DPEND 12'h060
`define PSE_OFF_DCLR 12'h068
`define PSE_OFF_EVT_EN 12'h070
`define PSE_OFF_IRQ_STAT 12'h080
`define PSE_OFF_IRQ_MASK 12'h084
// field positions
`define PSE_BIT_REEVAL 0
`define PSE_BIT_M14 14
`define PSE_BIT_M15 15
`define PSE_BIT_D1 1
`define PSE_EN_M14_ALT 0
`define PSE_EN_M14_RST 1
`define PSE_EN_M15_ALT 2
`define PSE_EN_M15_RST 3
`define PSE_EN_D1_ALT 4
`define PSE_ST_INST0 0
`define PSE_ST_INST1 1
// revision word, arbitrary neutral value
`define PSE_REV_VAL 32'hA5C3_0001
// reset values
`define PSE_RST_EN0 5'h00
`define PSE_RST_EN1 32'h0000_0000
`define PSE_RST_MASK 2'h0
`endif

// ===== design/pse_pkg.sv
// Purpose: types shared by the error interrupt block and its bench
// Assumes: constants come from pse_cfg.svh
// Notes: structs only, no numbers
`include "pse_cfg.svh"
package pse_pkg;
	// one register bus request
	typedef struct packed {
		logic [`PSE_AW-1:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} pse_bus_req_t;
	// emulation flags of one module
	typedef struct packed {
		logic alter;
		logic reset;
	} pse_mod_flags_t;
	// event pulses of the first instance
	typedef struct packed {
		logic m15_alter;
		logic m15_reset;
		logic m14_alter;
		logic m14_reset;
		logic d1_alter;
	} pse_evt0_t;
endpackage

// ===== design/pse_regs.sv
// Purpose: error and emulation pending bits, clears and combined interrupt
// Assumes: single clock mclk, synchronous active-low reset, plain reg port
// Notes: combined interrupt outputs are one-cycle pulses per instance
`timescale 1ns/1ps
`include "pse_cfg.svh"
module pse_regs
	import pse_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input pse_bus_req_t bus_req,
	output logic [31:0] bus_rdata,
	// event pulses, first instance
	input pse_evt0_t evt0,
	// event pulses, second instance, one per module
	input wire logic [31:0] mod_err_evt1,
	// combined interrupt pulses toward the interrupt controller
	output logic combined_power_interrupt0,
	output logic combined_power_interrupt1,
	// summary level interrupt
	output logic irq,
	// emulation flags seen by the module status logic
	output pse_mod_flags_t module15_status,
	output pse_mod_flags_t module14_status,
	output logic domain1_status
);

	// address split into instance select and offset
	logic inst1;
	logic [11:0] off;
	assign inst1 = bus_req.addr[`PSE_INST_BIT];
	assign off = bus_req.addr[11:0];

	// write strobes, one per writable register, and the status read strobe
	logic wr_reeval0, wr_reeval1;
	logic wr_mclr0, wr_mclr1;
	logic wr_dclr0;
	logic wr_en0, wr_en1;
	logic wr_mask;
	logic rd_stat;

	// decode, all strobes single cycle
	always_comb begin
		wr_reeval0 = bus_req.wr && !inst1 && off == `PSE_OFF_REEVAL;
		wr_reeval1 = bus_req.wr && inst1 && off == `PSE_OFF_REEVAL;
		wr_mclr0 = bus_req.wr && !inst1 && off == `PSE_OFF_MCLR;
		wr_mclr1 = bus_req.wr && inst1 && off == `PSE_OFF_MCLR;
		wr_dclr0 = bus_req.wr && !inst1 && off == `PSE_OFF_DCLR;
		wr_en0 = bus_req.wr && !inst1 && off == `PSE_OFF_EVT_EN;
		wr_en1 = bus_req.wr && inst1 && off == `PSE_OFF_EVT_EN;
		wr_mask = bus_req.wr && !inst1 && off == `PSE_OFF_IRQ_MASK;
		rd_stat = bus_req.rd && !inst1 && off == `PSE_OFF_IRQ_STAT;
	end

	// event enables, first instance (5 bits) and second (32 bits)
	logic [4:0] en0_ff;
	logic [31:0] en1_ff;

	// software steers which events may pend
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			en0_ff <= `PSE_RST_EN0;
			en1_ff <= `PSE_RST_EN1;
		end else begin
			if (wr_en0) begin
				en0_ff <= bus_req.wdata[4:0];
			end
			if (wr_en1) begin
				en1_ff <= bus_req.wdata;
			end
		end
	end

	// gated event set terms, first instance
	logic set_m15_alt, set_m15_rst;
	logic set_m14_alt, set_m14_rst;
	logic set_d1_alt;
	assign set_m15_alt = evt0.m15_alter && en0_ff[`PSE_EN_M15_ALT];
	assign set_m15_rst = evt0.m15_reset && en0_ff[`PSE_EN_M15_RST];
	assign set_m14_alt = evt0.m14_alter && en0_ff[`PSE_EN_M14_ALT];
	assign set_m14_rst = evt0.m14_reset && en0_ff[`PSE_EN_M14_RST];
	assign set_d1_alt = evt0.d1_alter && en0_ff[`PSE_EN_D1_ALT];

	// clear bits from the write data, zeros do nothing
	logic clr_m15, clr_m14, clr_d1;
	assign clr_m15 = wr_mclr0 && bus_req.wdata[`PSE_BIT_M15];
	assign clr_m14 = wr_mclr0 && bus_req.wdata[`PSE_BIT_M14];
	assign clr_d1 = wr_dclr0 && bus_req.wdata[`PSE_BIT_D1];

	// pending and flag state of the first instance
	logic pend_m15_ff, pend_m14_ff, pend_d1_ff;
	pse_mod_flags_t flg15_ff, flg14_ff;
	logic flg_d1_ff;

	// module 15: a set in the clearing cycle survives
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pend_m15_ff <= 1'b0;
			flg15_ff <= '0;
		end else begin
			pend_m15_ff <= (pend_m15_ff && !clr_m15) || set_m15_alt || set_m15_rst;
			flg15_ff.alter <= (flg15_ff.alter && !clr_m15) || set_m15_alt;
			flg15_ff.reset <= (flg15_ff.reset && !clr_m15) || set_m15_rst;
		end
	end

	// module 14: same shape as module 15
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pend_m14_ff <= 1'b0;
			flg14_ff <= '0;
		end else begin
			pend_m14_ff <= (pend_m14_ff && !clr_m14) || set_m14_alt || set_m14_rst;
			flg14_ff.alter <= (flg14_ff.alter && !clr_m14) || set_m14_alt;
			flg14_ff.reset <= (flg14_ff.reset && !clr_m14) || set_m14_rst;
		end
	end

	// domain 1 pending and its status flag
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pend_d1_ff <= 1'b0;
			flg_d1_ff <= 1'b0;
		end else begin
			pend_d1_ff <= (pend_d1_ff && !clr_d1) || set_d1_alt;
			flg_d1_ff <= (flg_d1_ff && !clr_d1) || set_d1_alt;
		end
	end

	// second instance: one pending bit per module
	logic [31:0] pend1_ff;
	logic [31:0] set1;
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_mod1
			// gated set and per-bit clear, set wins
			assign set1[gi] = mod_err_evt1[gi] && en1_ff[gi];
			always_ff @(posedge mclk) begin
				if (!rst_n) begin
					pend1_ff[gi] <= 1'b0;
				end else begin
					pend1_ff[gi] <= (pend1_ff[gi] && !(wr_mclr1 && bus_req.wdata[gi]))
						|| set1[gi];
				end
			end
		end
	endgenerate

	// assembled pending words, reserved bits forced to zero
	logic [31:0] mpend0, dpend0;
	always_comb begin
		mpend0 = 32'h0000_0000;
		mpend0[`PSE_BIT_M15] = pend_m15_ff;
		mpend0[`PSE_BIT_M14] = pend_m14_ff;
		dpend0 = 32'h0000_0000;
		dpend0[`PSE_BIT_D1] = pend_d1_ff;
	end

	// any pending status left in each instance
	logic any0, any1;
	assign any0 = pend_m15_ff || pend_m14_ff || pend_d1_ff;
	assign any1 = |pend1_ff;

	// combined pulse causes; only bit 0 of re-evaluate acts
	logic reeval0, reeval1;
	logic nxt_comb0, nxt_comb1;
	always_comb begin
		reeval0 = wr_reeval0 && bus_req.wdata[`PSE_BIT_REEVAL];
		reeval1 = wr_reeval1 && bus_req.wdata[`PSE_BIT_REEVAL];
		// fresh event fires at once, no wait for the pending bit
		nxt_comb0 = set_m15_alt || set_m15_rst || set_m14_alt
			|| set_m14_rst || set_d1_alt;
		nxt_comb1 = |set1;
		// re-evaluate looks at the pending bits as they stand now
		if (reeval0 && any0) begin
			nxt_comb0 = 1'b1;
		end
		if (reeval1 && any1) begin
			nxt_comb1 = 1'b1;
		end
	end

	// combined interrupt pulses, registered
	logic comb0_ff, comb1_ff;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			comb0_ff <= 1'b0;
			comb1_ff <= 1'b0;
		end else begin
			comb0_ff <= nxt_comb0;
			comb1_ff <= nxt_comb1;
		end
	end

	// sticky summary status, cleared by a read of itself
	logic [1:0] stat_ff, mask_ff;
	logic [1:0] nxt_stat;
	always_comb begin
		nxt_stat = rd_stat ? 2'h0 : stat_ff;
		// an event in the reading cycle is kept for the next read
		nxt_stat[`PSE_ST_INST0] = nxt_stat[`PSE_ST_INST0] || nxt_comb0;
		nxt_stat[`PSE_ST_INST1] = nxt_stat[`PSE_ST_INST1] || nxt_comb1;
	end

	// status and mask registers
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			stat_ff <= 2'h0;
			mask_ff <= `PSE_RST_MASK;
		end else begin
			stat_ff <= nxt_stat;
			if (wr_mask) begin
				mask_ff <= bus_req.wdata[1:0];
			end
		end
	end

	// level interrupt from the same next values, so no extra lag
	logic irq_ff;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_stat & mask_ff);
		end
	end

	// read mux; write-only and unmapped places give zero
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		if (!inst1) begin
			case (off)
				`PSE_OFF_REV: rd_val = `PSE_REV_VAL;
				`PSE_OFF_MPEND: rd_val = mpend0;
				`PSE_OFF_DPEND: rd_val = dpend0;
				`PSE_OFF_EVT_EN: rd_val = {27'h0000000, en0_ff};
				`PSE_OFF_IRQ_STAT: rd_val = {30'h00000000, stat_ff};
				`PSE_OFF_IRQ_MASK: rd_val = {30'h00000000, mask_ff};
				default: rd_val = 32'h0000_0000;
			endcase
		end else begin
			case (off)
				`PSE_OFF_REV: rd_val = `PSE_REV_VAL;
				`PSE_OFF_MPEND: rd_val = pend1_ff;
				`PSE_OFF_EVT_EN: rd_val = en1_ff;
				default: rd_val = 32'h0000_0000;
			endcase
		end
	end

	// read data stand only in the cycle after the strobe
	logic [31:0] rdata_ff;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else begin
			rdata_ff <= bus_req.rd ? rd_val : 32'h0000_0000;
		end
	end

	// outputs straight from flip-flops
	assign bus_rdata = rdata_ff;
	assign combined_power_interrupt0 = comb0_ff;
	assign combined_power_interrupt1 = comb1_ff;
	assign irq = irq_ff;
	assign module15_status = flg15_ff;
	assign module14_status = flg14_ff;
	assign domain1_status = flg_d1_ff;

endmodule

// ===== tb/pse_regs_asserts.sv
// Purpose: port checks on pse_regs
// Assumes: one clock, synchronous active-low reset
// Notes: enables are unseen, so raises tie to flag edges
`timescale 1ns/1ps
`include "pse_cfg.svh"
module pse_regs_chk
	import pse_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input pse_bus_req_t bus_req,
	input wire logic [31:0] bus_rdata,
	// events and outputs
	input pse_evt0_t evt0,
	input wire logic combined_power_interrupt0,
	input wire logic combined_power_interrupt1,
	input pse_mod_flags_t module15_status,
	input pse_mod_flags_t module14_status,
	input wire logic domain1_status
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// decoded instance 0 accesses
	wire logic [12:0] a = bus_req.addr;
	wire logic r_rev = bus_req.rd && a == {1'b0, `PSE_OFF_REV};
	wire logic r_wo = bus_req.rd && (a == {1'b0, `PSE_OFF_REEVAL} || a == {1'b0, `PSE_OFF_MCLR});
	wire logic r_mp = bus_req.rd && a == {1'b0, `PSE_OFF_MPEND};
	wire logic w_mc = bus_req.wr && a == {1'b0, `PSE_OFF_MCLR};
	wire logic w_dc = bus_req.wr && a == {1'b0, `PSE_OFF_DCLR};
	wire logic w_re = bus_req.wr && a == {1'b0, `PSE_OFF_REEVAL};
	a_rev_value: assert property (r_rev |=> bus_rdata == `PSE_REV_VAL)
		else $error("revision word wrong");
	a_wo_zero: assert property (r_wo |=> bus_rdata == 32'h0)
		else $error("write-only read not zero");
	a_mpend_rsvd: assert property (r_mp |=> bus_rdata[31:16] == 16'h0 && bus_rdata[13:0] == 14'h0)
		else $error("reserved pending bit set");
	a_m15_clear: assert property (w_mc && bus_req.wdata[15] && !evt0.m15_alter
		&& !evt0.m15_reset |=> module15_status == 2'h0)
		else $error("module 15 flags kept");
	a_m14_clear: assert property (w_mc && bus_req.wdata[14] && !evt0.m14_alter
		&& !evt0.m14_reset |=> module14_status == 2'h0)
		else $error("module 14 flags kept");
	a_dom_clear: assert property (w_dc && bus_req.wdata[1] && !evt0.d1_alter |=> !domain1_status)
		else $error("domain flag kept");
	a_raise_now: assert property ($rose(module15_status.alter) || $rose(module14_status.reset)
		|-> combined_power_interrupt0)
		else $error("no interrupt with new event");
	a_reeval_zero: assert property (w_re && !bus_req.wdata[0] && evt0 == '0
		|=> !combined_power_interrupt0)
		else $error("zero write re-raised");
	c_reeval: cover property (w_re && bus_req.wdata[0] ##1 combined_power_interrupt0);
	c_inst1: cover property (combined_power_interrupt1);
	c_clear: cover property (w_mc ##1 module15_status == 2'h0);
endmodule

bind pse_regs pse_regs_chk u_chk (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .evt0(evt0), .combined_power_interrupt0(combined_power_interrupt0),
	.combined_power_interrupt1(combined_power_interrupt1), .module15_status(module15_status),
	.module14_status(module14_status), .domain1_status(domain1_status));

// ===== tb/pse_intc.sv
// Purpose: stand-in for the device interrupt controller
// Assumes: combined interrupt is a one-cycle pulse
// Notes: counts pulses so each re-assertion is seen
`timescale 1ns/1ps
module pse_intc (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// combined interrupt pulse
	input wire logic int0,
	// pulse count
	output logic [7:0] hits_ff
);
	// every pulse is a fresh request, none merged
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hits_ff <= 8'h00;
		end else begin
			hits_ff <= hits_ff + {7'h0, int0};
		end
	end
endmodule

// ===== tb/pse_regs_bench.sv
// Purpose: self-checking bench for pse_regs
// Assumes: read data one cycle after rd, events seen next cycle
// Notes: all latencies fixed, so no handshake waits
`timescale 1ns/1ps
module pse_regs_bench import pse_pkg::*;;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	pse_bus_req_t bus_req = '0;
	pse_evt0_t evt0 = '0;
	logic [31:0] ev1 = 32'h0;
	logic [31:0] rdat;
	logic ci0, ci1, irq, d1;
	pse_mod_flags_t m15, m14;
	logic [7:0] h0;
	int miscompares = 0;
	int n_tests = 0;
	// reset reads: address beside expected word, last is unmapped
	logic [12:0] r_adr [7] = '{13'h0000, 13'h1000, 13'h0018, 13'h0040, 13'h0060, 13'h0084,
		13'h00FC};
	logic [31:0] r_exp [7] = '{32'hA5C3_0001, 32'hA5C3_0001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
	always #50 mclk = ~mclk;
	pse_regs u_dut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(rdat),
		.evt0(evt0), .mod_err_evt1(ev1), .combined_power_interrupt0(ci0),
		.combined_power_interrupt1(ci1), .irq(irq), .module15_status(m15),
		.module14_status(m14), .domain1_status(d1));
	pse_intc u_intc (.mclk(mclk), .rst_n(rst_n), .int0(ci0), .hits_ff(h0));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bus cycles, strobe one cycle then dropped
	task automatic wr(input logic [12:0] a, input logic [31:0] d);
		@(posedge mclk) bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk) bus_req <= '0;
		#1;
	endtask
	task automatic rd(input logic [12:0] a, input logic [31:0] e);
		@(posedge mclk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge mclk) bus_req <= '0;
		#1 chk(rdat, e);
	endtask
	// event pulse of one cycle
	task automatic ev(input pse_evt0_t v0, input logic [31:0] v1);
		@(posedge mclk) {evt0, ev1} <= {v0, v1};
		@(posedge mclk) {evt0, ev1} <= '0;
		#1;
	endtask
	task automatic give_verdict();
		if (miscompares == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		#1 chk({29'h0, ci0, irq, d1}, 32'h0);
		for (int i = 0; i < 7; i++) rd(r_adr[i], r_exp[i]);
		ev(5'h10, 32'h0);
		rd(13'h0040, 32'h0);
		wr(13'h0070, 32'h1F);
		wr(13'h0084, 32'h3);
		wr(13'h1070, 32'hFFFF_FFFF);
		ev(5'h10, 32'h0);
		chk({28'h0, ci0, irq, m15}, 32'hE);
		ev(5'h02, 32'h0);
		chk({30'h0, m14}, 32'h1);
		rd(13'h0040, 32'h0000_C000);
		ev(5'h01, 32'h0);
		rd(13'h0060, 32'h2);
		chk({31'h0, d1}, 32'h1);
		rd(13'h0080, 32'h1);
		@(posedge mclk) #1 chk({31'h0, irq}, 32'h0);
		wr(13'h0018, 32'hFFFF_FFFE);
		chk({31'h0, ci0}, 32'h0);
		wr(13'h0018, 32'h1);
		chk({31'h0, ci0}, 32'h1);
		// service: clear one module at a time, then re-evaluate
		wr(13'h0050, 32'h0000_4000);
		rd(13'h0040, 32'h0000_8000);
		chk({28'h0, m15, m14}, 32'h8);
		wr(13'h0050, 32'hFFFF_BFFF);
		wr(13'h0068, 32'h2);
		rd(13'h0040, 32'h0);
		rd(13'h0060, 32'h0);
		chk({27'h0, m15, m14, d1}, 32'h0);
		wr(13'h0018, 32'h1);
		chk({31'h0, ci0}, 32'h0);
		chk({24'h0, h0}, 32'h4);
		rd(13'h0080, 32'h1);
		wr(13'h0084, 32'h1);
		ev(5'h00, 32'h8000_0001);
		chk({30'h0, ci1, irq}, 32'h2);
		rd(13'h1040, 32'h8000_0001);
		wr(13'h1050, 32'h1);
		rd(13'h1040, 32'h8000_0000);
		rd(13'h0080, 32'h2);
		// reset in mid-run drops pending bits, enables and outputs
		@(posedge mclk) rst_n <= 1'b0;
		@(posedge mclk) rst_n <= 1'b1;
		#1 chk({28'h0, ci0, ci1, irq, d1}, 32'h0);
		rd(13'h1040, 32'h0);
		ev(5'h10, 32'h0);
		chk({29'h0, ci0, m15}, 32'h0);
		rd(13'h0040, 32'h0);
		give_verdict();
	end
endmodule
